/* input_check_config.sv */
// configuration register, alarms and interrupt for the parallel input checks
// assumes a register master that issues one-cycle strobes, reads back a cycle later
//
// Behaviour
// - pattern check bit runs the pattern checker
// - pattern check forces outputs off regardless
// - auto clear alarms after 64 good samples
// - parity sense: zero even, one odd
// - word parity checked on parity pair
// - strobe parity uses strobe as parity
// - reverse rotates sync, parity, strobe inputs
// - invert bit complements channel A data
// - bits 14, 13 and 0 reserved, zero
// - config at 0x01, reset 0x040e
`timescale 1ns/1ns
`default_nettype none

module input_check_config #(
    parameter int RUN_LEN = icc_pkg::GOOD_RUN_LEN
) (
    // clock and reset
    input  wire logic            clk_i,
    input  wire logic            rst_b_i,
    // register port
    input  wire icc_pkg::addr_t  addr_i,
    input  wire icc_pkg::word_t  wr_data_i,
    input  wire logic            wr_i,
    input  wire logic            rd_i,
    output icc_pkg::word_t       rd_data_o,
    // input data interface
    input  wire icc_pkg::word_t  data_i,
    input  wire logic            valid_i,
    input  wire logic            parity_input_pair_i,
    input  wire logic            sync_input_pair_i,
    input  wire logic            strobe_input_pair_i,
    // transmit enables
    input  wire logic            transmit_enable_pin_i,
    input  wire logic            transmit_enable_bit_i,
    // channel A path and controls
    output icc_pkg::word_t       channel_a_output_o,
    output logic                 channel_a_valid_o,
    output logic                 sync_o,
    output logic                 input_strobe_o,
    output logic                 output_active_o,
    // alarms and interrupt
    output icc_pkg::alarm_t      alarm_o,
    output logic                 irq_o
);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    icc_pkg::word_t  config_reg;
    icc_pkg::word_t  pattern;
    icc_pkg::irq_t   irq_mask;
    icc_pkg::irq_t   irq_status;
    icc_pkg::alarm_t alarm;
    icc_pkg::irq_t   next_irq_status;
    icc_pkg::irq_t   next_irq_mask;
    icc_pkg::alarm_t next_alarm;
    icc_pkg::irq_t   events;
    icc_pkg::alarm_t alarm_set;
    icc_pkg::alarm_t alarm_wr_clr;

    logic wr_config;
    logic wr_pattern;
    logic wr_mask;
    logic wr_alarm;
    logic rd_status;

    // rotated control inputs
    logic eff_strobe;
    logic eff_sync;
    logic eff_parity;

    chk_if chk ();

    always_comb
    begin
        wr_config  = wr_i && (addr_i == icc_pkg::ADDR_CONFIG);
        wr_pattern = wr_i && (addr_i == icc_pkg::ADDR_PATTERN);
        wr_mask    = wr_i && (addr_i == icc_pkg::ADDR_IRQ_MASK);
        wr_alarm   = wr_i && (addr_i == icc_pkg::ADDR_ALARM);
        rd_status  = rd_i && (addr_i == icc_pkg::ADDR_IRQ_STATUS);
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            config_reg <= icc_pkg::CONFIG_RESET;
        else if (wr_config)
            config_reg <= wr_data_i & icc_pkg::CONFIG_WMASK;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            pattern <= icc_pkg::PATTERN_RESET;
        else if (wr_pattern)
            pattern <= wr_data_i;
    end

    // ------------------------------------------------------------------
    // control input rotation
    // ------------------------------------------------------------------
    always_comb
    begin
        if (config_reg[icc_pkg::BIT_REVERSE])
        begin
            eff_strobe = sync_input_pair_i;
            eff_sync   = parity_input_pair_i;
            eff_parity = strobe_input_pair_i;
        end
        else
        begin
            eff_strobe = strobe_input_pair_i;
            eff_sync   = sync_input_pair_i;
            eff_parity = parity_input_pair_i;
        end
    end

    // ------------------------------------------------------------------
    // checker and run counter
    // ------------------------------------------------------------------
    // the source is trusted to drive parity in the programmed sense
    always_comb
    begin
        chk.valid       = valid_i;
        chk.word        = data_i;
        chk.par_bit     = eff_parity;
        chk.strb_bit    = eff_strobe;
        chk.odd_sense   = config_reg[icc_pkg::BIT_ODD_SENSE];
        chk.word_par_en = config_reg[icc_pkg::BIT_WORD_PAR];
        chk.strb_par_en = config_reg[icc_pkg::BIT_STRB_PAR];
        chk.pattern_en  = config_reg[icc_pkg::BIT_PATTERN_EN];
        chk.auto_clr_en = config_reg[icc_pkg::BIT_AUTO_CLEAR];
        chk.pattern     = pattern;
    end

    sample_check u_sample_check (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .chk     (chk.check)
    );

    good_run_count #(
        .RUN_LEN (RUN_LEN)
    ) u_good_run_count (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .chk     (chk.count)
    );

    // ------------------------------------------------------------------
    // alarms
    // ------------------------------------------------------------------
    // a new mismatch outranks any clear in the same cycle
    always_comb
    begin
        alarm_set = '0;
        alarm_set[icc_pkg::ALARM_PARITY]  = chk.err_parity;
        alarm_set[icc_pkg::ALARM_PATTERN] = chk.err_pattern;
        alarm_wr_clr = wr_alarm ? wr_data_i[icc_pkg::ALARM_W-1:0] : '0;
        if (chk.run_done)
            next_alarm = alarm_set;
        else
            next_alarm = (alarm & ~alarm_wr_clr) | alarm_set;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            alarm <= '0;
        else
            alarm <= next_alarm;
    end

    // ------------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------------
    always_comb
    begin
        events = '0;
        events[icc_pkg::IRQ_PARITY]   = chk.err_parity;
        events[icc_pkg::IRQ_PATTERN]  = chk.err_pattern;
        events[icc_pkg::IRQ_AUTO_CLR] = chk.run_done;
        next_irq_status = (rd_status ? '0 : irq_status) | events;
        next_irq_mask   = wr_mask ? wr_data_i[icc_pkg::IRQ_W-1:0] : irq_mask;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            irq_status <= '0;
        else
            irq_status <= next_irq_status;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            irq_mask <= icc_pkg::IRQ_MASK_RESET;
        else
            irq_mask <= next_irq_mask;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(next_irq_status & next_irq_mask);
    end

    // ------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------
    // unmapped addresses read zero; data stand only in the cycle after rd_i
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i || !rd_i)
            rd_data_o <= icc_pkg::WORD_ZERO;
        else
        begin
            case (addr_i)
                icc_pkg::ADDR_CONFIG:     rd_data_o <= config_reg;
                icc_pkg::ADDR_PATTERN:    rd_data_o <= pattern;
                icc_pkg::ADDR_IRQ_STATUS: rd_data_o <= icc_pkg::word_t'(irq_status);
                icc_pkg::ADDR_IRQ_MASK:   rd_data_o <= icc_pkg::word_t'(irq_mask);
                icc_pkg::ADDR_ALARM:      rd_data_o <= icc_pkg::word_t'(alarm);
                default:                  rd_data_o <= icc_pkg::WORD_ZERO;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // output path
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            channel_a_output_o <= icc_pkg::WORD_ZERO;
            channel_a_valid_o  <= 1'b0;
            sync_o             <= 1'b0;
            input_strobe_o     <= 1'b0;
        end
        else
        begin
            channel_a_output_o <= config_reg[icc_pkg::BIT_INVERT_A] ? ~data_i : data_i;
            channel_a_valid_o  <= valid_i;
            sync_o             <= eff_sync;
            // strobe carries parity in that mode, so it no longer marks words
            input_strobe_o     <= eff_strobe && !config_reg[icc_pkg::BIT_STRB_PAR];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            output_active_o <= 1'b0;
        else
            output_active_o <= transmit_enable_pin_i && transmit_enable_bit_i &&
                               !config_reg[icc_pkg::BIT_PATTERN_EN];
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            alarm_o <= '0;
        else
            alarm_o <= next_alarm;
    end

endmodule : input_check_config

`default_nettype wire

/* icc_pkg.sv */
// constants, types and helpers shared by the input check configuration block
// assumes a 16-bit register port with byte-free word access and 8-bit addresses
package icc_pkg;

    // ------------------------------------------------------------------
    // widths and types
    // ------------------------------------------------------------------
    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;
    localparam int IRQ_W  = 3;
    localparam int ALARM_W = 2;

    typedef logic [DATA_W-1:0]  word_t;
    typedef logic [ADDR_W-1:0]  addr_t;
    typedef logic [IRQ_W-1:0]   irq_t;
    typedef logic [ALARM_W-1:0] alarm_t;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam addr_t ADDR_CONFIG     = 8'h01;
    localparam addr_t ADDR_IRQ_STATUS = 8'h10;
    localparam addr_t ADDR_IRQ_MASK   = 8'h11;
    localparam addr_t ADDR_ALARM      = 8'h12;
    localparam addr_t ADDR_PATTERN    = 8'h13;

    localparam word_t CONFIG_RESET  = 16'h040e;
    // bits 14, 13 and 0 are reserved and always read as zero
    localparam word_t CONFIG_WMASK  = 16'h9ffe;
    localparam word_t PATTERN_RESET = 16'h0000;
    localparam irq_t  IRQ_MASK_RESET = 3'h0;
    localparam word_t WORD_ZERO     = 16'h0000;

    // ------------------------------------------------------------------
    // configuration field positions
    // ------------------------------------------------------------------
    localparam int BIT_PATTERN_EN = 15;
    localparam int BIT_AUTO_CLEAR = 12;
    localparam int BIT_ODD_SENSE  = 11;
    localparam int BIT_WORD_PAR   = 10;
    localparam int BIT_STRB_PAR   = 9;
    localparam int BIT_REVERSE    = 8;
    localparam int BIT_INVERT_A   = 7;

    // status, mask and alarm field positions
    localparam int IRQ_PARITY   = 0;
    localparam int IRQ_PATTERN  = 1;
    localparam int IRQ_AUTO_CLR = 2;
    localparam int ALARM_PARITY  = 0;
    localparam int ALARM_PATTERN = 1;

    // consecutive good samples before alarms clear themselves
    localparam int GOOD_RUN_LEN = 64;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // true when word plus carried bit meet the selected sense (odd = 1)
    function automatic logic parity_ok(input word_t w, input logic p, input logic odd);
        parity_ok = ((^w) ^ p) == odd;
    endfunction : parity_ok

endpackage : icc_pkg

/* chk_if.sv */
// bundle between the register hub, the sample checker and the good-run counter
// assumes all three parties share one clock, supplied to each module directly
`timescale 1ns/1ns
`default_nettype none

interface chk_if;
    logic          valid;
    icc_pkg::word_t word;
    logic          par_bit;
    logic          strb_bit;
    logic          odd_sense;
    logic          word_par_en;
    logic          strb_par_en;
    logic          pattern_en;
    logic          auto_clr_en;
    icc_pkg::word_t pattern;
    logic          err_parity;
    logic          err_pattern;
    logic          good;
    logic          run_done;

    modport hub (
        output valid, word, par_bit, strb_bit, odd_sense, word_par_en, strb_par_en,
        output pattern_en, auto_clr_en, pattern,
        input  err_parity, err_pattern, good, run_done
    );
    modport check (
        input  valid, word, par_bit, strb_bit, odd_sense, word_par_en, strb_par_en,
        input  pattern_en, pattern,
        output err_parity, err_pattern, good
    );
    modport count (
        input  good, err_parity, err_pattern, auto_clr_en,
        output run_done
    );
endinterface : chk_if

`default_nettype wire

/* sample_check.sv */
// per-sample parity and pattern checker, one registered verdict per sample
// assumes the hub presents the parity and strobe bits already rotated, with valid alongside
`timescale 1ns/1ns
`default_nettype none

module sample_check (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    // checker bundle
    chk_if.check      chk
);

    logic word_bad;
    logic strb_bad;
    logic pat_bad;

    always_comb
    begin
        word_bad = chk.word_par_en &&
                   !icc_pkg::parity_ok(chk.word, chk.par_bit, chk.odd_sense);
        strb_bad = chk.strb_par_en &&
                   !icc_pkg::parity_ok(chk.word, chk.strb_bit, chk.odd_sense);
        pat_bad  = chk.pattern_en && (chk.word != chk.pattern);
    end

    // verdicts are one-cycle pulses, one cycle after the sample
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            chk.err_parity  <= 1'b0;
            chk.err_pattern <= 1'b0;
            chk.good        <= 1'b0;
        end
        else
        begin
            chk.err_parity  <= chk.valid && (word_bad || strb_bad);
            chk.err_pattern <= chk.valid && pat_bad;
            chk.good        <= chk.valid && !(word_bad || strb_bad || pat_bad);
        end
    end

endmodule : sample_check

`default_nettype wire

/* good_run_count.sv */
// counts consecutive good samples and pulses run_done at the end of a run
// assumes good and the error pulses never rise in the same cycle
`timescale 1ns/1ns
`default_nettype none

module good_run_count #(
    parameter int RUN_LEN = icc_pkg::GOOD_RUN_LEN
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    // counter bundle
    chk_if.count      chk
);

    localparam int CNT_W = $clog2(RUN_LEN + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(RUN_LEN - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);
    localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

    logic [CNT_W-1:0] run_cnt;

    // any bad sample restarts the run; idle cycles keep it
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i || !chk.auto_clr_en || chk.err_parity || chk.err_pattern)
            run_cnt <= CNT_ZERO;
        else if (chk.good)
            run_cnt <= (run_cnt == CNT_LAST) ? CNT_ZERO : run_cnt + CNT_ONE;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            chk.run_done <= 1'b0;
        else
            chk.run_done <= chk.auto_clr_en && chk.good && (run_cnt == CNT_LAST);
    end

endmodule : good_run_count

`default_nettype wire

/* icc_assertions.sv */
// checker for the input check configuration block, on its top ports only
// assumes one clock domain; bound from the bench top file
`timescale 1ns/1ns
`default_nettype none

module icc_assertions #(
    parameter int RUN_LEN = 64
) (
    // clock, reset and register port
    input wire logic            clk_i,
    input wire logic            rst_b_i,
    input wire icc_pkg::addr_t  addr_i,
    input wire icc_pkg::word_t  wr_data_i,
    input wire logic            wr_i,
    input wire logic            rd_i,
    input wire icc_pkg::word_t  rd_data_o,
    // input bus and enables
    input wire icc_pkg::word_t  data_i,
    input wire logic            valid_i,
    input wire logic            parity_input_pair_i,
    input wire logic            sync_input_pair_i,
    input wire logic            strobe_input_pair_i,
    input wire logic            transmit_enable_pin_i,
    input wire logic            transmit_enable_bit_i,
    // outputs
    input wire icc_pkg::word_t  channel_a_output_o,
    input wire logic            channel_a_valid_o,
    input wire logic            sync_o,
    input wire logic            input_strobe_o,
    input wire logic            output_active_o,
    input wire icc_pkg::alarm_t alarm_o,
    input wire logic            irq_o
);
    // --------------------------------------------------------------
    // shadow of the config and pattern registers
    // --------------------------------------------------------------
    icc_pkg::word_t cfg;
    icc_pkg::word_t pat;
    icc_pkg::word_t ch_a_exp;
    logic           rot_par, rot_strb, rot_sync, live;
    logic           strb_exp;
    logic           act_exp;
    logic           no_clr;
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            cfg <= icc_pkg::CONFIG_RESET;
            pat <= icc_pkg::PATTERN_RESET;
        end
        else if (wr_i && addr_i == icc_pkg::ADDR_CONFIG)
            cfg <= wr_data_i & icc_pkg::CONFIG_WMASK;
        else if (wr_i && addr_i == icc_pkg::ADDR_PATTERN)
            pat <= wr_data_i;
    end
    assign rot_par  = cfg[8] ? strobe_input_pair_i : parity_input_pair_i;
    assign rot_strb = cfg[8] ? sync_input_pair_i : strobe_input_pair_i;
    assign rot_sync = cfg[8] ? parity_input_pair_i : sync_input_pair_i;
    assign strb_exp = !cfg[9] && rot_strb;
    assign act_exp  = transmit_enable_pin_i && transmit_enable_bit_i && !cfg[15];
    assign ch_a_exp = cfg[7] ? ~data_i : data_i;
    assign no_clr   = !cfg[12] && !(wr_i && addr_i == icc_pkg::ADDR_ALARM);

    // --------------------------------------------------------------
    // properties
    // --------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    // release edge still holds reset values in sampled state, so wait one cycle
    always_ff @(posedge clk_i) live <= rst_b_i;
    default disable iff (!rst_b_i || !live);

    cfg_read_a: assert property (rd_i && addr_i == icc_pkg::ADDR_CONFIG |=>
        rd_data_o == $past(cfg)) else $error("config read back wrong");
    out_off_a: assert property (1'b1 |=> output_active_o == $past(act_exp))
        else $error("output enable wrong");
    invert_a: assert property (valid_i |=> channel_a_output_o == $past(ch_a_exp))
        else $error("channel a data wrong");
    sync_rot_a: assert property (valid_i |=> sync_o == $past(rot_sync))
        else $error("sync rotation wrong");
    strb_rot_a: assert property (valid_i |=> input_strobe_o == $past(strb_exp))
        else $error("strobe output wrong");
    word_par_a: assert property (valid_i && cfg[10] && ((^data_i ^ rot_par) != cfg[11])
        |-> ##2 alarm_o[0]) else $error("word parity miss");
    strb_par_a: assert property (valid_i && cfg[9] && ((^data_i ^ rot_strb) != cfg[11])
        |-> ##2 alarm_o[0]) else $error("strobe parity miss");
    pattern_hit_a: assert property (valid_i && cfg[15] && data_i != pat |-> ##2 alarm_o[1])
        else $error("pattern miss");
    alarm_sticky_a: assert property (no_clr |=> (alarm_o & $past(alarm_o)) == $past(alarm_o))
        else $error("alarm dropped");

    cover property (valid_i && cfg[15]);
    cover property (irq_o);
    cover property (cfg[12] && $fell(alarm_o[0]));
endmodule : icc_assertions

`default_nettype wire

/* icc_source.sv */
// data source model driving the parallel input bus
// assumes bench requests change right after a rising clock edge
`timescale 1ns/1ns
`default_nettype none

module icc_source (
    // clock and requests
    input  wire logic           clk_i,
    input  wire logic           go_i,
    input  wire icc_pkg::word_t word_i,
    input  wire logic           odd_i,
    input  wire logic           bad_i,
    input  wire logic           sync_i,
    // parallel bus
    output icc_pkg::word_t      data_o,
    output logic                valid_o,
    output logic                parity_o,
    output logic                sync_o,
    output logic                strobe_o
);
    icc_pkg::word_t last = 16'h0f0f;
    logic           par;
    // idle lines change every cycle so a stale copy is never read
    always @(posedge clk_i)
        last <= go_i ? word_i : ~last;
    // parity goes out on both pins so either check mode sees it
    assign par      = (^word_i) ^ odd_i ^ bad_i;
    assign valid_o  = go_i;
    assign data_o   = go_i ? word_i : ~last;
    assign parity_o = go_i ? par : ~last[0];
    assign strobe_o = go_i ? par : last[1];
    assign sync_o   = go_i ? sync_i : ~last[2];
endmodule : icc_source

`default_nettype wire

/* input_check_config_bench.sv */
// self-checking bench for the input check configuration block
// assumes package, design, source model and checker compiled before it
`timescale 1ns/1ns
`default_nettype none

module input_check_config_bench;
    localparam int RUN = 4;
    logic            clk_i = 1'b0;
    logic            rst_b_i = 1'b0;
    icc_pkg::addr_t  addr_i = 8'h00;
    icc_pkg::word_t  wr_data_i = 16'h0000;
    logic            wr_i = 1'b0;
    logic            rd_i = 1'b0;
    logic            transmit_enable_pin_i = 1'b1;
    logic            transmit_enable_bit_i = 1'b1;
    logic            go = 1'b0;
    icc_pkg::word_t  word = 16'h0000;
    logic            odd = 1'b0;
    logic            bad = 1'b0;
    logic            sync_req = 1'b0;
    icc_pkg::word_t  rd_data_o, data_i, channel_a_output_o, got;
    logic            valid_i, parity_input_pair_i, sync_input_pair_i, strobe_input_pair_i;
    logic            channel_a_valid_o, sync_o, input_strobe_o, output_active_o, irq_o;
    icc_pkg::alarm_t alarm_o;
    int              n_fail = 0;
    int              cmp_count = 0;

    always #2 clk_i = ~clk_i;

    input_check_config #(.RUN_LEN(RUN)) dut_u (.clk_i, .rst_b_i, .addr_i, .wr_data_i,
        .wr_i, .rd_i, .rd_data_o, .data_i, .valid_i, .parity_input_pair_i,
        .sync_input_pair_i, .strobe_input_pair_i, .transmit_enable_pin_i,
        .transmit_enable_bit_i, .channel_a_output_o, .channel_a_valid_o, .sync_o,
        .input_strobe_o, .output_active_o, .alarm_o, .irq_o);
    icc_source src_u (.clk_i, .go_i(go), .word_i(word), .odd_i(odd), .bad_i(bad),
        .sync_i(sync_req), .data_o(data_i), .valid_o(valid_i), .parity_o(parity_input_pair_i),
        .sync_o(sync_input_pair_i), .strobe_o(strobe_input_pair_i));

    // --------------------------------------------------------------
    // tasks
    // --------------------------------------------------------------
    task automatic chk(input icc_pkg::word_t g, input icc_pkg::word_t e, input string what);
        cmp_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("Error at %0t: %s got %h expected %h", $time, what, g, e);
        end
    endtask : chk
    task automatic step;
        @(posedge clk_i);
        #1;
    endtask : step
    task automatic wr_reg(input icc_pkg::addr_t a, input icc_pkg::word_t d);
        @(posedge clk_i);
        addr_i    <= a;
        wr_data_i <= d;
        wr_i      <= 1'b1;
        step();
        wr_i      <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input icc_pkg::addr_t a, output icc_pkg::word_t d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        step();
        rd_i   <= 1'b0;
        d = rd_data_o;
    endtask : rd_reg
    // one sample; returns just after the edge that takes it
    task automatic send(input icc_pkg::word_t w, input logic b);
        @(posedge clk_i);
        word <= w;
        bad  <= b;
        go   <= 1'b1;
        step();
        go   <= 1'b0;
    endtask : send
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    // --------------------------------------------------------------
    // tests
    // --------------------------------------------------------------
    initial
    begin
        #20000;
        n_fail++;
        tally_and_finish();
    end

    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd_reg(icc_pkg::ADDR_CONFIG, got);
        chk(got, 16'h040e, "config reset");
        wr_reg(icc_pkg::ADDR_CONFIG, 16'hffff);
        rd_reg(icc_pkg::ADDR_CONFIG, got);
        chk(got, 16'h9ffe, "reserved bits");
        wr_reg(8'h20, 16'hffff);
        rd_reg(8'h20, got);
        chk(got, 16'h0000, "unmapped read");
        $display("registers done");
        for (int s = 0; s < 2; s++)
        begin
            odd <= s[0];
            wr_reg(icc_pkg::ADDR_CONFIG, {4'h0, s[0], 11'h400});
            send(16'h00f1, 1'b0);
            step();
            chk({14'h0, alarm_o}, 16'h0000, "good parity");
            send(16'h00f1, 1'b1);
            step();
            chk({14'h0, alarm_o}, 16'h0001, "bad parity");
            wr_reg(icc_pkg::ADDR_ALARM, 16'h0003);
            chk({14'h0, alarm_o}, 16'h0000, "alarm clear");
        end
        wr_reg(icc_pkg::ADDR_CONFIG, 16'h0000);
        send(16'h0003, 1'b1);
        step();
        chk({14'h0, alarm_o}, 16'h0000, "checks off");
        wr_reg(icc_pkg::ADDR_CONFIG, 16'h0a00);
        send(16'h0000, 1'b0);
        chk({15'h0, input_strobe_o}, 16'h0000, "strobe muted");
        step();
        chk({14'h0, alarm_o}, 16'h0000, "strobe parity good");
        send(16'h0000, 1'b1);
        step();
        chk({14'h0, alarm_o}, 16'h0001, "strobe parity bad");
        $display("parity done");
        rd_reg(icc_pkg::ADDR_IRQ_STATUS, got);
        wr_reg(icc_pkg::ADDR_IRQ_MASK, 16'h0001);
        send(16'h0000, 1'b1);
        step();
        chk({15'h0, irq_o}, 16'h0001, "irq raised");
        rd_reg(icc_pkg::ADDR_IRQ_STATUS, got);
        chk(got, 16'h0001, "status");
        chk({15'h0, irq_o}, 16'h0000, "irq cleared");
        wr_reg(icc_pkg::ADDR_IRQ_MASK, 16'h0000);
        send(16'h0000, 1'b1);
        step();
        chk({15'h0, irq_o}, 16'h0000, "irq masked");
        $display("interrupt done");
        wr_reg(icc_pkg::ADDR_ALARM, 16'h0003);
        rd_reg(icc_pkg::ADDR_IRQ_STATUS, got);
        wr_reg(icc_pkg::ADDR_PATTERN, 16'h1234);
        wr_reg(icc_pkg::ADDR_CONFIG, 16'h8000);
        step();
        chk({15'h0, output_active_o}, 16'h0000, "outputs off");
        send(16'h1234, 1'b0);
        step();
        chk({14'h0, alarm_o}, 16'h0000, "pattern match");
        send(16'h1235, 1'b0);
        step();
        chk({14'h0, alarm_o}, 16'h0002, "pattern miss");
        wr_reg(icc_pkg::ADDR_CONFIG, 16'h0000);
        step();
        chk({15'h0, output_active_o}, 16'h0001, "outputs on");
        $display("pattern done");
        wr_reg(icc_pkg::ADDR_ALARM, 16'h0003);
        rd_reg(icc_pkg::ADDR_IRQ_STATUS, got);
        wr_reg(icc_pkg::ADDR_CONFIG, 16'h1c00);
        send(16'h0005, 1'b1);
        repeat (RUN - 1) send(16'h0005, 1'b0);
        step();
        chk({14'h0, alarm_o}, 16'h0001, "run short");
        send(16'h0005, 1'b0);
        repeat (2) step();
        chk({14'h0, alarm_o}, 16'h0000, "run cleared");
        rd_reg(icc_pkg::ADDR_IRQ_STATUS, got);
        chk(got, 16'h0005, "auto clear status");
        $display("auto clear done");
        wr_reg(icc_pkg::ADDR_CONFIG, 16'h0c80);
        send(16'h1357, 1'b0);
        chk(channel_a_output_o, 16'heca8, "inverted");
        chk({15'h0, channel_a_valid_o}, 16'h0001, "valid delayed");
        wr_reg(icc_pkg::ADDR_CONFIG, 16'h0c00);
        sync_req <= 1'b1;
        send(16'h0001, 1'b0);
        chk(channel_a_output_o, 16'h0001, "straight");
        chk({14'h0, sync_o, input_strobe_o}, 16'h0002, "no rotation");
        wr_reg(icc_pkg::ADDR_CONFIG, 16'h0d00);
        send(16'h0001, 1'b0);
        chk({14'h0, sync_o, input_strobe_o}, 16'h0001, "rotation");
        step();
        chk({14'h0, alarm_o}, 16'h0000, "reversed parity");
        $display("data path done");
        tally_and_finish();
    end
endmodule : input_check_config_bench

bind input_check_config icc_assertions #(.RUN_LEN(RUN_LEN)) chk_u (.clk_i, .rst_b_i,
    .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o, .data_i, .valid_i, .parity_input_pair_i,
    .sync_input_pair_i, .strobe_input_pair_i, .transmit_enable_pin_i, .transmit_enable_bit_i,
    .channel_a_output_o, .channel_a_valid_o, .sync_o, .input_strobe_o, .output_active_o,
    .alarm_o, .irq_o);

`default_nettype wire
